// file: core/psp_pkg.sv
// Purpose: Constants and carrier types of the pot SPI peripheral port.
// Assumes: SPI modes (0,0) and (1,1), most significant bit first.
// Notes: Behaviour list follows.
// Behaviour
// RL1: System ties the interface select pin low to choose the SPI port.
// RL2: Host starts each command sequence by taking chip select from high to low.
// RL3: Chip select high resets the serial interface; clock and data are ignored.
// RL4: 4096 pulses with chip select and data low reset the serial interface.
// RL5: That reset drives data out high and sets the serial reset flag.
// RL6: Output stays high to the next falling edge (0,0) or chip select fall (1,1); the code holds it in (1,1) until chip select rises.
// RL7: That reset also sets the command error flag; a status read clears it.
// RL8: Data in is sampled on rising edges, data out changes on falling edges.
// RL9: Invalid code and address combinations set the command error flag.
// RL10: Codes: 00X write 24, 11X read 24, 010 increment 8, 100 decrement 8.
// RL11: First data byte carries value bits 9..8, second byte bits 7..0.
// RL12: Data out is driven low as soon as chip select goes active.
// RL13: While the error flag is set only reads execute.
// RL14: Soft reset clears the error flag but not the serial interface.
// RL15: A command executes only after its full clock count arrives; the code acts on a read after the eighth rising edge.
// RL16: A valid write updates the register on its last rising edge.
// RL17: Read ignores data in for 16 clocks and sends zeros before the value.
// RL18: Increment and decrement change the wiper after the eighth rising edge.
// RL19: Stepping a register that cannot step is refused and flags an error.
// RL20: Wiper saturates at 3FFh and 000h; a step past a limit flags an error.
// RL21: Command byte is five address bits over three code bits, MSB first.
// RL22: Wipers are ten bits; read data upper bits are zero.
`default_nettype none
package psp_pkg;
    localparam int CMD_BITS = 8;
    localparam int LONG_BITS = 24;
    localparam int VAL_BITS = 10;
    localparam int DATA_BITS = 16;
    localparam int ZR_W = 13;
    localparam int RESET_PULSES_DEF = 4096;
    localparam int NUM_WIPERS_DEF = 2;
    localparam int REG_COUNT_DEF = 4;
    localparam logic [1:0] CODE_WR_HI = 2'h0;
    localparam logic [1:0] CODE_RD_HI = 2'h3;
    localparam logic [2:0] CODE_INC = 3'h2;
    localparam logic [2:0] CODE_DEC = 3'h4;
    localparam logic [4:0] STATUS_ADDR = 5'h10;
    localparam int ST_ERR_POS = 0;
    localparam int ST_SRST_POS = 1;
    localparam logic [9:0] VAL_MAX = 10'h3FF;
    localparam logic [9:0] VAL_MIN = 10'h000;
    localparam logic [9:0] VAL_ONE = 10'h001;
    localparam logic [9:0] WIPER_RESET = 10'h000;
    localparam logic [4:0] BIT_CNT_ZERO = 5'h00;
    localparam logic [4:0] BIT_CNT_ONE = 5'h01;

    typedef struct packed {
        logic [4:0] addr;
        logic [2:0] code;
    } psp_cmd_t;

    typedef enum logic [2:0] {
        PH_CMD = 3'b001,
        PH_WR = 3'b010,
        PH_RD = 3'b100
    } psp_phase_t;

    typedef struct packed {
        psp_phase_t phase;
        logic [4:0] bit_cnt;
        logic [15:0] shreg;
        logic [ZR_W-1:0] zero_run;
        logic r_tog;
        logic hold_set;
        logic hold_m00;
    } psp_frame_t;

    typedef struct packed {
        psp_cmd_t cmd;
        logic [VAL_BITS-1:0] val;
        logic ex_tog;
        logic rd_tog;
        logic srst_tog;
        logic ack1;
        logic ack2;
    } psp_link_t;

    typedef struct packed {
        logic f_tog;
        logic sdo;
        logic hold_clr;
    } psp_fall_t;

    localparam psp_frame_t FRAME_RESET = '{phase: PH_CMD, default: '0};
endpackage : psp_pkg
`default_nettype wire

// file: core/psp_spi_port.sv
// Purpose: SPI peripheral front end with wiper registers and status flags.
// Assumes: sck far slower than ref_clk; read data needs about 2 sck cycles.
// Notes: Shift logic runs on sck; registers and flags on ref_clk.
`default_nettype none
module psp_spi_port
    import psp_pkg::*;
#(
    parameter int NUM_WIPERS = NUM_WIPERS_DEF,
    parameter int REG_COUNT = REG_COUNT_DEF,
    parameter int RESET_PULSES = RESET_PULSES_DEF
) (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic sck,
    input wire logic cs_n,
    input wire logic sdi,
    input wire logic interface_select_pin,
    input wire logic soft_reset,
    output logic sdo,
    output logic sdo_oe,
    output logic [NUM_WIPERS-1:0][VAL_BITS-1:0] wiper_value,
    output logic command_error_flag,
    output logic serial_reset_flag
);
    localparam int AW = $clog2(REG_COUNT);

    typedef struct packed {
        logic [2:0] ex_s;
        logic [2:0] rd_s;
        logic [2:0] sr_s;
        logic ack_tog;
        logic [DATA_BITS-1:0] rd_data;
        logic [REG_COUNT-1:0][VAL_BITS-1:0] regs;
        logic err;
        logic srst;
    } psp_ref_t;

    localparam psp_ref_t REF_RESET = '{regs: {REG_COUNT{WIPER_RESET}}, default: '0};

    function automatic logic [AW-1:0] reg_idx(input logic [4:0] a);
        return a[AW-1:0];
    endfunction : reg_idx

    function automatic logic addr_in(input logic [4:0] a, input int limit);
        return int'(a) < limit;
    endfunction : addr_in

    psp_frame_t fr;
    psp_frame_t next_fr;
    psp_link_t lk;
    psp_link_t next_lk;
    psp_fall_t fl;
    psp_fall_t next_fl;
    psp_ref_t rq;
    psp_ref_t next_rq;

    logic frame_rst;
    psp_cmd_t cmd_now;
    logic last_cmd_edge;
    logic last_long_edge;
    logic rd_ready;
    logic [4:0] rd_pos;
    logic ex_evt;
    logic rd_evt;
    logic sr_evt;
    logic set_err;
    logic clr_err;
    logic [AW-1:0] idx;
    logic [VAL_BITS-1:0] cur;

    // Interface held in reset while deselected or while the pin picks the other port
    assign frame_rst = rst | cs_n | interface_select_pin; // RL3 RL1

    // Output driven low from the moment chip select falls
    assign sdo_oe = ~cs_n & ~interface_select_pin; // RL12
    assign sdo = (fr.hold_set & ~fl.hold_clr) | fl.sdo; // RL5 RL6

    assign cmd_now = psp_cmd_t'({fr.shreg[6:0], sdi}); // RL21
    assign last_cmd_edge = fr.bit_cnt == 5'(CMD_BITS - 1);
    assign last_long_edge = fr.bit_cnt == 5'(LONG_BITS - 1);
    assign rd_ready = lk.ack2 == lk.rd_tog;
    assign rd_pos = 5'(LONG_BITS - 1) - fr.bit_cnt;

    // Rising edge side: shift in, frame commands, watch for the clock-only reset
    always_comb begin
        next_fr = fr;
        next_lk = lk;
        next_fr.r_tog = ~fr.r_tog;
        next_fr.shreg = {fr.shreg[14:0], sdi}; // RL8
        next_fr.bit_cnt = fr.bit_cnt + BIT_CNT_ONE;
        next_lk.ack1 = rq.ack_tog;
        next_lk.ack2 = lk.ack1;
        unique case (fr.phase)
            PH_CMD: begin
                if (last_cmd_edge) begin
                    next_lk.cmd = cmd_now;
                    if (cmd_now.code[2:1] == CODE_WR_HI) begin // RL10
                        next_fr.phase = PH_WR;
                    end else if (cmd_now.code[2:1] == CODE_RD_HI) begin
                        next_fr.phase = PH_RD;
                        next_lk.rd_tog = ~lk.rd_tog;
                    end else begin
                        next_lk.ex_tog = ~lk.ex_tog; // RL18 RL9
                        next_fr.bit_cnt = BIT_CNT_ZERO;
                    end
                end
            end
            PH_WR: begin
                if (last_long_edge) begin
                    next_lk.val = {fr.shreg[8:0], sdi}; // RL11
                    next_lk.ex_tog = ~lk.ex_tog; // RL15 RL16
                    next_fr.phase = PH_CMD;
                    next_fr.bit_cnt = BIT_CNT_ZERO;
                end
            end
            PH_RD: begin
                if (last_long_edge) begin
                    next_fr.phase = PH_CMD; // RL17
                    next_fr.bit_cnt = BIT_CNT_ZERO;
                end
            end
        endcase
        if (sdi) begin
            next_fr.zero_run = '0;
        end else begin
            next_fr.zero_run = fr.zero_run + ZR_W'(1);
        end
        if (!sdi && fr.zero_run == ZR_W'(RESET_PULSES - 1)) begin // RL4
            next_fr.phase = PH_CMD;
            next_fr.bit_cnt = BIT_CNT_ZERO;
            next_fr.zero_run = '0;
            next_fr.hold_set = 1'b1; // RL5
            next_fr.hold_m00 = fr.r_tog == fl.f_tog; // RL6
            next_lk.ex_tog = lk.ex_tog;
            next_lk.rd_tog = lk.rd_tog;
            next_lk.srst_tog = ~lk.srst_tog;
        end
    end

    always_ff @(posedge sck or posedge frame_rst) begin
        if (frame_rst) begin
            fr <= FRAME_RESET; // RL3
        end else begin
            fr <= next_fr;
        end
    end

    always_ff @(posedge sck or posedge rst) begin
        if (rst) begin
            lk <= '0;
        end else begin
            lk <= next_lk;
        end
    end

    // Falling edge side: drive read data, end the mode (0,0) hold
    always_comb begin
        next_fl = fl;
        next_fl.f_tog = ~fl.f_tog;
        next_fl.hold_clr = fl.hold_clr | (fr.hold_set & fr.hold_m00); // RL6
        next_fl.sdo = 1'b0;
        if (fr.phase == PH_RD && rd_ready) begin
            next_fl.sdo = rq.rd_data[rd_pos[3:0]]; // RL8 RL17
        end
    end

    always_ff @(negedge sck or posedge frame_rst) begin
        if (frame_rst) begin
            fl <= '0;
        end else begin
            fl <= next_fl;
        end
    end

    // Register side on ref_clk
    assign ex_evt = rq.ex_s[2] ^ rq.ex_s[1];
    assign rd_evt = rq.rd_s[2] ^ rq.rd_s[1];
    assign sr_evt = rq.sr_s[2] ^ rq.sr_s[1];
    assign idx = reg_idx(lk.cmd.addr);
    assign cur = rq.regs[idx];

    always_comb begin
        next_rq = rq;
        set_err = 1'b0;
        clr_err = soft_reset; // RL14
        next_rq.ex_s = {rq.ex_s[1:0], lk.ex_tog};
        next_rq.rd_s = {rq.rd_s[1:0], lk.rd_tog};
        next_rq.sr_s = {rq.sr_s[1:0], lk.srst_tog};
        if (rd_evt) begin
            next_rq.ack_tog = ~rq.ack_tog;
            next_rq.rd_data = '0; // RL22
            if (lk.cmd.addr == STATUS_ADDR) begin
                next_rq.rd_data[ST_ERR_POS] = rq.err;
                next_rq.rd_data[ST_SRST_POS] = rq.srst;
                clr_err = 1'b1; // RL7
            end else if (addr_in(lk.cmd.addr, REG_COUNT)) begin
                next_rq.rd_data[VAL_BITS-1:0] = cur; // RL13
            end else begin
                set_err = 1'b1; // RL9
            end
        end
        if (ex_evt) begin
            if (lk.cmd.code[2:1] == CODE_WR_HI) begin
                if (!addr_in(lk.cmd.addr, REG_COUNT)) begin
                    set_err = 1'b1; // RL9
                end else if (!rq.err) begin
                    next_rq.regs[idx] = lk.val; // RL16 RL13
                end
            end else if (lk.cmd.code == CODE_INC) begin
                if (!addr_in(lk.cmd.addr, NUM_WIPERS) || cur == VAL_MAX) begin
                    set_err = 1'b1; // RL19 RL20
                end else if (!rq.err) begin
                    next_rq.regs[idx] = cur + VAL_ONE; // RL18 RL13
                end
            end else if (lk.cmd.code == CODE_DEC) begin
                if (!addr_in(lk.cmd.addr, NUM_WIPERS) || cur == VAL_MIN) begin
                    set_err = 1'b1; // RL19 RL20
                end else if (!rq.err) begin
                    next_rq.regs[idx] = cur - VAL_ONE; // RL18 RL13
                end
            end else begin
                set_err = 1'b1; // RL9
            end
        end
        if (soft_reset) begin
            next_rq.srst = 1'b0;
        end
        if (sr_evt) begin
            next_rq.srst = 1'b1; // RL5
            set_err = 1'b1; // RL7
        end
        next_rq.err = (rq.err & ~clr_err) | set_err;
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            rq <= REF_RESET;
        end else begin
            rq <= next_rq;
        end
    end

    always_comb begin
        for (int i = 0; i < NUM_WIPERS; i++) begin
            wiper_value[i] = rq.regs[i];
        end
    end

    assign command_error_flag = rq.err;
    assign serial_reset_flag = rq.srst;
endmodule : psp_spi_port
`default_nettype wire

// file: tb/psp_spi_port_properties.sv
// Purpose: Port assertions for the pot SPI front end.
// Assumes: Sampled on ref_clk.
// Notes: Bound from the bench.
`default_nettype none
module psp_spi_port_properties
    import psp_pkg::*;
#(
    parameter int NUM_WIPERS = NUM_WIPERS_DEF
) (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic sck,
    input wire logic cs_n,
    input wire logic interface_select_pin,
    input wire logic soft_reset,
    input wire logic sdo,
    input wire logic sdo_oe,
    input wire logic [NUM_WIPERS-1:0][VAL_BITS-1:0] wiper_value,
    input wire logic command_error_flag,
    input wire logic serial_reset_flag
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge ref_clk);
    endclocking
    default disable iff (rst);
    a_oe_on_select: assert property (sdo_oe == (!cs_n && !interface_select_pin))
        else $error("sdo_oe wrong");
    a_idle_sdo_low: assert property (cs_n |-> !sdo) else $error("sdo high idle");
    a_idle_regs_hold: assert property (cs_n && $past(cs_n, 8) |-> $stable(wiper_value))
        else $error("wiper moved idle");
    a_soft_clears_err: assert property (soft_reset && cs_n && $past(cs_n, 8)
        |=> !command_error_flag) else $error("error kept");
    a_soft_clears_srst: assert property (soft_reset && cs_n && $past(cs_n, 8)
        |=> !serial_reset_flag) else $error("serial flag kept");
    a_error_blocks_step: assert property ($past(command_error_flag) && !$past(soft_reset)
        |-> $stable(wiper_value)) else $error("wiper moved in error");
    a_srst_sets_err: assert property ($rose(serial_reset_flag) |-> command_error_flag)
        else $error("error not set");
    a_sdo_falls_low: assert property ($fell(sdo) && !cs_n && !$past(cs_n) |-> !sck)
        else $error("sdo edge off");
    c_srst: cover property ($rose(serial_reset_flag));
    c_err: cover property ($rose(command_error_flag));
    c_wiper: cover property ($changed(wiper_value));
endmodule : psp_spi_port_properties
`default_nettype wire

// file: tb/psp_host_model.sv
// Purpose: SPI host model for the pot SPI front end.
// Assumes: Modes (0,0) and (1,1), 48 ns clock.
// Notes: Clock stands still between frames.
`default_nettype none
module psp_host_model (
    output logic sck,
    output logic cs_n,
    output logic sdi,
    input wire logic sdo
);
    timeunit 1ns;
    timeprecision 1ps;
    logic mode = 1'b0;
    initial begin
        sck = 1'b0;
        cs_n = 1'b1;
        sdi = 1'b0;
    end
    task automatic start(input logic m);
        mode = m;
        sck = m;
        #20.37;
        cs_n = 1'b0;
        #24;
    endtask : start
    task automatic shift(input int n, input logic [23:0] v, output logic [23:0] r);
        r = '0;
        for (int i = n - 1; i >= 0; i--) begin
            sck = 1'b0;
            sdi = v[i];
            #12;
            r[i] = sdo;
            #12;
            sck = 1'b1;
            #24;
        end
    endtask : shift
    task automatic stop(output logic last);
        if (!mode) sck = 1'b0;
        #24;
        last = sdo;
        cs_n = 1'b1;
        sdi = ~sdi;
        #48;
    endtask : stop
endmodule : psp_host_model
`default_nettype wire

// file: tb/test_pot_spi_peripheral_port.sv
// Purpose: Self-checking bench for the pot SPI front end.
// Assumes: Clock-only reset shortened to 16 pulses.
// Notes: Integer model checked after every frame.
`default_nettype none
module test_pot_spi_peripheral_port
    import psp_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int PULSES = 16;
    logic ref_clk = 1'b0;
    logic rst = 1'b1;
    logic interface_select_pin = 1'b0;
    logic soft_reset = 1'b0;
    logic sck, cs_n, sdi, sdo, sdo_oe, command_error_flag, serial_reset_flag;
    logic [NUM_WIPERS_DEF-1:0][VAL_BITS-1:0] wiper_value;
    logic [23:0] got;
    logic last_bit;
    logic [31:0] seed = 32'h29C5E8D0;
    int bad_count = 0;
    int n_compared = 0;
    int mem[4] = '{default: 0};
    int err = 0;
    int srf = 0;
    psp_spi_port #(.RESET_PULSES(PULSES)) u_dut (.ref_clk, .rst, .sck, .cs_n, .sdi,
        .interface_select_pin, .soft_reset, .sdo, .sdo_oe, .wiper_value,
        .command_error_flag, .serial_reset_flag);
    psp_host_model u_host (.sck, .cs_n, .sdi, .sdo);
    initial begin
        forever #4 ref_clk = ~ref_clk;
    end
    initial begin
        #500000;
        bad_count++;
        $display("ERROR %0t watchdog", $time);
        final_report();
    end
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : rnd
    task automatic check(input logic [23:0] seen, input logic [23:0] exp);
        n_compared++;
        if (seen !== exp) begin
            bad_count++;
            $display("ERROR %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic state_chk();
        check(24'(wiper_value), 24'({10'(mem[1]), 10'(mem[0])}));
        check(24'({command_error_flag, serial_reset_flag}), 24'({err[0], srf[0]}));
    endtask : state_chk
    task automatic pulse_soft();
        #40;
        @(negedge ref_clk) soft_reset = 1'b1;
        @(negedge ref_clk) soft_reset = 1'b0;
        err = 0;
        srf = 0;
    endtask : pulse_soft
    function automatic int model(input logic [7:0] c, input int d);
        int a;
        int r;
        a = int'(c[7:3]);
        r = 0;
        case (c[2:0])
            3'h0, 3'h1: if (a > 3) err = 1; else if (err == 0) mem[a] = d % 1024;
            3'h6, 3'h7: begin
                r = (a < 4) ? mem[a] : (a == 16) ? srf * 2 + err : 0;
                if (a > 3 && a != 16) err = 1;
            end
            3'h2, 3'h4: begin
                if (a > 1 || mem[a] == (c[2] ? 0 : 1023)) err = 1;
                else if (err == 0) mem[a] += c[2] ? -1 : 1;
            end
            default: err = 1;
        endcase
        if (c[7:1] == 7'h43) err = 0;
        return r;
    endfunction : model
    task automatic frame(input logic m, input logic [7:0] c, input logic [15:0] d);
        int n;
        int r;
        n = (c[2] == c[1]) ? 24 : 8;
        u_host.start(m);
        check(24'({sdo_oe, sdo}), 24'h2);
        u_host.shift(n, (n == 24) ? {c, d} : {16'h0, c}, got);
        r = model(c, int'(d));
        u_host.stop(last_bit);
        if (n == 24 && c[2]) check(got, 24'(r));
        state_chk();
    endtask : frame
    task automatic final_report();
        $display("compared %0d mismatches %0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : final_report
    initial begin
        logic [31:0] x;
        logic [9:0] v;
        repeat (3) @(posedge ref_clk);
        @(negedge ref_clk) rst = 1'b0;
        for (int m = 0; m < 2; m++) begin
            pulse_soft();
            u_host.start(m[0]);
            u_host.shift(PULSES, 24'h0, got);
            check(24'(sdo), 24'h1);
            u_host.stop(got[0]);
            check(24'(got[0]), 24'(m));
            err = 1;
            srf = 1;
            state_chk();
            frame(m[0], 8'h86, 16'h8000);
        end
        pulse_soft();
        @(negedge ref_clk) interface_select_pin = 1'b1;
        u_host.start(1'b0);
        check(24'({sdo_oe, sdo}), 24'h0);
        u_host.shift(24, 24'h008155, got);
        u_host.stop(last_bit);
        @(negedge ref_clk) interface_select_pin = 1'b0;
        state_chk();
        frame(1'b0, 8'h00, 16'h83FE);
        u_host.start(1'b1);
        u_host.shift(20, 24'h00883F, got);
        u_host.stop(got[0]);
        state_chk();
        u_host.start(1'b0);
        u_host.shift(16, 24'h000202, got);
        u_host.stop(got[0]);
        void'(model(8'h02, 0));
        void'(model(8'h02, 0));
        state_chk();
        repeat (80) begin
            x = rnd();
            v = x[17] ? x[29:20] : {10{x[16]}};
            if (x[20:18] == 3'h0) pulse_soft();
            frame(x[31], {x[4] & x[3], 2'h0, x[1:0], x[10:8]}, {1'b1, x[15:11], v});
        end
        final_report();
    end
endmodule : test_pot_spi_peripheral_port
bind psp_spi_port psp_spi_port_properties #(.NUM_WIPERS(NUM_WIPERS)) u_props (.ref_clk, .rst,
    .sck, .cs_n, .interface_select_pin, .soft_reset, .sdo, .sdo_oe, .wiper_value,
    .command_error_flag, .serial_reset_flag);
`default_nettype wire
